// [inc/cch_params.svh]
// Purpose: Constants for the calendar clock with hold
// Assumes: 10 MHz system clock
// Notes: Offsets are byte addresses on the register bus
`ifndef CCH_PARAMS_SVH
`define CCH_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CCH_OFS_CTRL 12'h000
`define CCH_OFS_STATUS 12'h004
`define CCH_OFS_SET_TIME 12'h008
`define CCH_OFS_SET_DATE 12'h00c
`define CCH_OFS_TIME 12'h010
`define CCH_OFS_DATE 12'h014

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CCH_CTRL_HOLD 0
`define CCH_CTRL_RELEASE 1
`define CCH_CTRL_SET 2
`define CCH_ST_UPDATE 0
`define CCH_ST_DISABLED 1
`define CCH_ST_RANGE_ERR 2
`define CCH_ST_SET_OK 3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CCH_CLK_HZ 10000000
`define CCH_TICK_HZ 1
`define CCH_TICK_CYCLES (`CCH_CLK_HZ / `CCH_TICK_HZ)

`endif

// [inc/cch_pkg.sv]
// Purpose: Types for the calendar clock with hold
// Assumes: Nothing
// Notes: Weekday codes run Sunday 0 to Saturday 6
package cch_pkg;

    typedef enum logic [2:0] {
        CCH_SUNDAY = 3'h0,
        CCH_MONDAY = 3'h1,
        CCH_TUESDAY = 3'h2,
        CCH_WEDNESDAY = 3'h3,
        CCH_THURSDAY = 3'h4,
        CCH_FRIDAY = 3'h5,
        CCH_SATURDAY = 3'h6
    } cch_weekday_t;

    typedef enum logic [1:0] {
        CCH_WR_IDLE = 2'h0,
        CCH_WR_RESP = 2'h1
    } cch_wr_state_t;

endpackage : cch_pkg

// [core/cch_tick_gen.sv]
// Purpose: One-second tick from the system clock
// Assumes: Clock enable freezes the count
// Notes: Tick is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
`include "cch_params.svh"

module cch_tick_gen #(
    parameter int unsigned TICK_CYCLES = `CCH_TICK_CYCLES
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    output logic tick_out
);

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;

    always_comb
    begin
        cnt_d = cnt_q;
        if (ce_in)
        begin
            if (cnt_q >= TICK_CYCLES - 1)
                cnt_d = 32'h0;
            else
                cnt_d = cnt_q + 32'h1;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            cnt_q <= 32'h0;
        else
            cnt_q <= cnt_d;
    end

    assign tick_out = ce_in && (cnt_q >= TICK_CYCLES - 1);

endmodule : cch_tick_gen
`default_nettype wire

// [core/cch_date_check.sv]
// Purpose: Range check of a requested date and time
// Assumes: Values arrive in binary
// Notes: Purely combinational
`timescale 1ns/1ns
`default_nettype none

module cch_date_check (
    input wire logic [4:0] hour_in,
    input wire logic [5:0] min_in,
    input wire logic [5:0] sec_in,
    input wire logic [4:0] day_in,
    input wire logic [3:0] month_in,
    input wire logic [6:0] year_in,
    input wire logic [2:0] wday_in,
    output logic ok_out
);

    always_comb
    begin
        ok_out = (hour_in <= 5'h17) && (min_in <= 6'h3b) && (sec_in <= 6'h3b)
            && (day_in >= 5'h01) && (day_in <= 5'h1f)
            && (month_in >= 4'h1) && (month_in <= 4'hc)
            && (year_in <= 7'h63) && (wday_in <= 3'h6);
    end

endmodule : cch_date_check
`default_nettype wire

// [core/cch_calendar_clock.sv]
// Purpose: Calendar clock with hold, registers over AXI4-Lite
// Assumes: Backup supply keeps mclk_in and this logic alive
// Notes: Functional notes
// Functional notes
// - Counting runs continuously on backup power; the count stops while ce_in is low
// - Update-needed flag set when content invalid
// - Hour shown in 24-hour form 0..23
// - Hour shown 1..12 plus afternoon flag
// - Minutes, seconds, day, month, year keep updating
// - Weekday shown and set as seven codes
// - Out-of-range setup rejected, range error flagged
// - Setup outcome reported 0 fail, 1 ok
// - Hold freezes visible values, count continues
// - Disabled flag set on hold, cleared on release
// - Release resumes visible values at current time
`timescale 1ns/1ns
`default_nettype none
`include "cch_params.svh"

module cch_calendar_clock #(
    parameter int unsigned TICK_CYCLES = `CCH_TICK_CYCLES
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [4:0] hours_24_out,
    output logic [3:0] hours_12_out,
    output logic afternoon_flag_out,
    output logic [5:0] minutes_out,
    output logic [5:0] seconds_out,
    output logic [4:0] day_out,
    output logic [3:0] month_out,
    output logic [6:0] year_out,
    output cch_pkg::cch_weekday_t weekday_value_out,
    output logic update_needed_out,
    output logic disabled_out
);

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    function automatic logic [4:0] month_len(input logic [3:0] m, input logic [6:0] y);
        logic [4:0] len;
        len = 5'h1f;
        case (m)
            4'h4, 4'h6, 4'h9, 4'hb: len = 5'h1e;
            4'h2: len = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            default: len = 5'h1f;
        endcase
        return len;
    endfunction : month_len

    function automatic logic [3:0] to_12h(input logic [4:0] h);
        logic [4:0] r;
        r = (h == 5'h00) ? 5'h0c : ((h > 5'h0c) ? h - 5'h0c : h);
        return r[3:0];
    endfunction : to_12h

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic [4:0] hour_q, hour_d;
    logic [5:0] min_q, min_d, sec_q, sec_d;
    logic [4:0] day_q, day_d;
    logic [3:0] mon_q, mon_d;
    logic [6:0] year_q, year_d;
    logic [2:0] wday_q, wday_d;
    logic [4:0] vis_hour_q, vis_hour_d;
    logic [5:0] vis_min_q, vis_min_d, vis_sec_q, vis_sec_d;
    logic [4:0] vis_day_q, vis_day_d;
    logic [3:0] vis_mon_q, vis_mon_d;
    logic [6:0] vis_year_q, vis_year_d;
    logic [2:0] vis_wday_q, vis_wday_d;
    logic need_q, need_d, hold_q, hold_d, rerr_q, rerr_d, setok_q, setok_d;
    logic [31:0] st_time_q, st_time_d, st_date_q, st_date_d;
    cch_pkg::cch_wr_state_t wst_q, wst_d;
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [11:0] aw_q, aw_d;
    logic [31:0] wd_q, wd_d;
    logic bad_wr_q, bad_wr_d;
    logic rv_q, rv_d;
    logic [31:0] rd_q, rd_d;
    logic [1:0] rr_q, rr_d;
    logic tick;
    logic range_ok;
    logic wr_fire, set_req, hold_req, rel_req;

    // ------------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------------
    cch_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .tick_out(tick)
    );

    cch_date_check u_chk (
        .hour_in(st_time_q[20:16]),
        .min_in(st_time_q[13:8]),
        .sec_in(st_time_q[5:0]),
        .day_in(st_date_q[4:0]),
        .month_in(st_date_q[11:8]),
        .year_in(st_date_q[22:16]),
        .wday_in(st_date_q[26:24]),
        .ok_out(range_ok)
    );

    // ------------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------------
    assign s_axi_awready = ce_in && (wst_q == cch_pkg::CCH_WR_IDLE) && !aw_got_q;
    assign s_axi_wready = ce_in && (wst_q == cch_pkg::CCH_WR_IDLE) && !w_got_q;
    assign s_axi_bvalid = (wst_q == cch_pkg::CCH_WR_RESP);
    assign s_axi_bresp = bad_wr_q ? 2'h2 : 2'h0;
    assign wr_fire = ce_in && (wst_q == cch_pkg::CCH_WR_IDLE) && aw_got_q && w_got_q;
    assign set_req = wr_fire && (aw_q == `CCH_OFS_CTRL) && wd_q[`CCH_CTRL_SET];
    assign hold_req = wr_fire && (aw_q == `CCH_OFS_CTRL) && wd_q[`CCH_CTRL_HOLD];
    assign rel_req = wr_fire && (aw_q == `CCH_OFS_CTRL) && wd_q[`CCH_CTRL_RELEASE];

    always_comb
    begin
        wst_d = wst_q;
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        aw_d = aw_q;
        wd_d = wd_q;
        bad_wr_d = bad_wr_q;
        st_time_d = st_time_q;
        st_date_d = st_date_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_d = 1'b1;
            aw_d = {s_axi_awaddr[11:2], 2'h0};
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_d = 1'b1;
            wd_d = s_axi_wdata;
            for (int i = 0; i < 4; i++)
            begin
                if (!s_axi_wstrb[i])
                    wd_d[i*8 +: 8] = 8'h00;
            end
        end
        case (wst_q)
            cch_pkg::CCH_WR_IDLE:
            begin
                if (wr_fire)
                begin
                    aw_got_d = 1'b0;
                    w_got_d = 1'b0;
                    wst_d = cch_pkg::CCH_WR_RESP;
                    bad_wr_d = 1'b0;
                    case (aw_q)
                        `CCH_OFS_CTRL: bad_wr_d = 1'b0;
                        `CCH_OFS_SET_TIME: st_time_d = wd_q;
                        `CCH_OFS_SET_DATE: st_date_d = wd_q;
                        `CCH_OFS_STATUS, `CCH_OFS_TIME, `CCH_OFS_DATE: bad_wr_d = 1'b0;
                        default: bad_wr_d = 1'b1;
                    endcase
                end
            end
            cch_pkg::CCH_WR_RESP:
            begin
                if (s_axi_bready && ce_in)
                    wst_d = cch_pkg::CCH_WR_IDLE;
            end
            default: wst_d = cch_pkg::CCH_WR_IDLE;
        endcase
    end

    // ------------------------------------------------------------------------
    // Time keeping
    // ------------------------------------------------------------------------
    always_comb
    begin
        hour_d = hour_q;
        min_d = min_q;
        sec_d = sec_q;
        day_d = day_q;
        mon_d = mon_q;
        year_d = year_q;
        wday_d = wday_q;
        need_d = need_q;
        hold_d = hold_q;
        rerr_d = rerr_q;
        setok_d = setok_q;
        if (tick)
        begin
            sec_d = sec_q + 6'h01;
            if (sec_q == 6'h3b)
            begin
                sec_d = 6'h00;
                min_d = min_q + 6'h01;
                if (min_q == 6'h3b)
                begin
                    min_d = 6'h00;
                    hour_d = hour_q + 5'h01;
                    if (hour_q == 5'h17)
                    begin
                        hour_d = 5'h00;
                        wday_d = (wday_q == 3'h6) ? 3'h0 : wday_q + 3'h1;
                        day_d = day_q + 5'h01;
                        if (day_q >= month_len(mon_q, year_q))
                        begin
                            day_d = 5'h01;
                            mon_d = mon_q + 4'h1;
                            if (mon_q == 4'hc)
                            begin
                                mon_d = 4'h1;
                                year_d = (year_q == 7'h63) ? 7'h00 : year_q + 7'h01;
                            end
                        end
                    end
                end
            end
        end
        if (set_req)
        begin
            setok_d = range_ok;
            rerr_d = !range_ok;
            if (range_ok)
            begin
                hour_d = st_time_q[20:16];
                min_d = st_time_q[13:8];
                sec_d = st_time_q[5:0];
                day_d = st_date_q[4:0];
                mon_d = st_date_q[11:8];
                year_d = st_date_q[22:16];
                wday_d = st_date_q[26:24];
                need_d = 1'b0;
            end
        end
        if (hold_req)
            hold_d = 1'b1;
        else if (rel_req)
            hold_d = 1'b0;
    end

    // ------------------------------------------------------------------------
    // Visible values
    // ------------------------------------------------------------------------
    always_comb
    begin
        vis_hour_d = vis_hour_q;
        vis_min_d = vis_min_q;
        vis_sec_d = vis_sec_q;
        vis_day_d = vis_day_q;
        vis_mon_d = vis_mon_q;
        vis_year_d = vis_year_q;
        vis_wday_d = vis_wday_q;
        if (ce_in && !hold_q)
        begin
            vis_hour_d = hour_q;
            vis_min_d = min_q;
            vis_sec_d = sec_q;
            vis_day_d = day_q;
            vis_mon_d = mon_q;
            vis_year_d = year_q;
            vis_wday_d = wday_q;
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------------
    assign s_axi_arready = ce_in && !rv_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;

    always_comb
    begin
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        if (rv_q && s_axi_rready && ce_in)
            rv_d = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rv_d = 1'b1;
            rr_d = 2'h0;
            case ({s_axi_araddr[11:2], 2'h0})
                `CCH_OFS_CTRL: rd_d = 32'h0;
                `CCH_OFS_STATUS: rd_d = {28'h0, setok_q, rerr_q, hold_q, need_q};
                `CCH_OFS_SET_TIME: rd_d = st_time_q;
                `CCH_OFS_SET_DATE: rd_d = st_date_q;
                `CCH_OFS_TIME: rd_d = {6'h0, afternoon_flag_out, hours_12_out,
                    vis_hour_q, 2'h0, vis_min_q, 2'h0, vis_sec_q};
                `CCH_OFS_DATE: rd_d = {5'h0, vis_wday_q, 1'b0, vis_year_q,
                    4'h0, vis_mon_q, 3'h0, vis_day_q};
                default:
                begin
                    rd_d = 32'h0;
                    rr_d = 2'h2;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            hour_q <= 5'h00;
            min_q <= 6'h00;
            sec_q <= 6'h00;
            day_q <= 5'h01;
            mon_q <= 4'h1;
            year_q <= 7'h00;
            wday_q <= 3'h0;
            vis_hour_q <= 5'h00;
            vis_min_q <= 6'h00;
            vis_sec_q <= 6'h00;
            vis_day_q <= 5'h01;
            vis_mon_q <= 4'h1;
            vis_year_q <= 7'h00;
            vis_wday_q <= 3'h0;
            need_q <= 1'b1;
            hold_q <= 1'b0;
            rerr_q <= 1'b0;
            setok_q <= 1'b0;
            st_time_q <= 32'h0;
            st_date_q <= 32'h0;
            wst_q <= cch_pkg::CCH_WR_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_q <= 12'h000;
            wd_q <= 32'h0;
            bad_wr_q <= 1'b0;
            rv_q <= 1'b0;
            rd_q <= 32'h0;
            rr_q <= 2'h0;
        end
        else if (ce_in)
        begin
            hour_q <= hour_d;
            min_q <= min_d;
            sec_q <= sec_d;
            day_q <= day_d;
            mon_q <= mon_d;
            year_q <= year_d;
            wday_q <= wday_d;
            vis_hour_q <= vis_hour_d;
            vis_min_q <= vis_min_d;
            vis_sec_q <= vis_sec_d;
            vis_day_q <= vis_day_d;
            vis_mon_q <= vis_mon_d;
            vis_year_q <= vis_year_d;
            vis_wday_q <= vis_wday_d;
            need_q <= need_d;
            hold_q <= hold_d;
            rerr_q <= rerr_d;
            setok_q <= setok_d;
            st_time_q <= st_time_d;
            st_date_q <= st_date_d;
            wst_q <= wst_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            aw_q <= aw_d;
            wd_q <= wd_d;
            bad_wr_q <= bad_wr_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign hours_24_out = vis_hour_q;
    assign hours_12_out = to_12h(vis_hour_q);
    assign afternoon_flag_out = (vis_hour_q >= 5'h0c);
    assign minutes_out = vis_min_q;
    assign seconds_out = vis_sec_q;
    assign day_out = vis_day_q;
    assign month_out = vis_mon_q;
    assign year_out = vis_year_q;
    assign weekday_value_out = cch_pkg::cch_weekday_t'(vis_wday_q);
    assign update_needed_out = need_q;
    assign disabled_out = hold_q;

endmodule : cch_calendar_clock
`default_nettype wire

// [verification/cch_calendar_clock_monitor.sv]
// Purpose: Port checks for the calendar clock
// Assumes: Bound into every cch_calendar_clock
// Notes: One clock domain
`timescale 1ns/1ns
`default_nettype none

module cch_calendar_clock_monitor #(
    parameter int unsigned TICK_CYCLES = 10
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic s_axi_bvalid,
    input wire logic [4:0] hours_24_out,
    input wire logic [3:0] hours_12_out,
    input wire logic afternoon_flag_out,
    input wire logic [5:0] minutes_out,
    input wire logic [5:0] seconds_out,
    input wire logic [4:0] day_out,
    input wire logic [3:0] month_out,
    input wire logic [6:0] year_out,
    input wire cch_pkg::cch_weekday_t weekday_value_out,
    input wire logic update_needed_out,
    input wire logic disabled_out
);
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);

    property p_r24;
        hours_24_out <= 5'h17;
    endproperty
    a_r24: assert property (p_r24) else $error("hour too big");
    property p_h12;
        hours_12_out == (((hours_24_out % 5'h0c) == 5'h00) ? 4'hc : 4'(hours_24_out % 5'h0c))
        && afternoon_flag_out == (hours_24_out >= 5'h0c);
    endproperty
    a_h12: assert property (p_h12) else $error("bad 12h hour");
    property p_ms;
        minutes_out <= 6'h3b && seconds_out <= 6'h3b;
    endproperty
    a_ms: assert property (p_ms) else $error("bad min or sec");
    property p_dmy;
        day_out >= 5'h01 && day_out <= 5'h1f && month_out >= 4'h1 && month_out <= 4'hc
        && year_out <= 7'h63 && 3'(weekday_value_out) <= 3'h6;
    endproperty
    a_dmy: assert property (p_dmy) else $error("bad date");
    property p_hold;
        disabled_out && $past(disabled_out) |-> $stable({seconds_out, minutes_out, day_out});
    endproperty
    a_hold: assert property (p_hold) else $error("held value moved");
    property p_dis;
        $changed(disabled_out) |-> $rose(s_axi_bvalid);
    endproperty
    a_dis: assert property (p_dis) else $error("hold flag moved alone");
    property p_upd;
        $changed(update_needed_out) |-> $fell(update_needed_out) && $rose(s_axi_bvalid);
    endproperty
    a_upd: assert property (p_upd) else $error("update flag moved");
    property p_step;
        $changed(seconds_out) && !$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)
        && !$past(disabled_out) |-> seconds_out ==
        (($past(seconds_out) == 6'h3b) ? 6'h00 : $past(seconds_out) + 6'h01);
    endproperty
    a_step: assert property (p_step) else $error("second skipped");
endmodule : cch_calendar_clock_monitor

bind cch_calendar_clock cch_calendar_clock_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .s_axi_bvalid(s_axi_bvalid),
    .hours_24_out(hours_24_out),
    .hours_12_out(hours_12_out),
    .afternoon_flag_out(afternoon_flag_out),
    .minutes_out(minutes_out),
    .seconds_out(seconds_out),
    .day_out(day_out),
    .month_out(month_out),
    .year_out(year_out),
    .weekday_value_out(weekday_value_out),
    .update_needed_out(update_needed_out),
    .disabled_out(disabled_out)
);
`default_nettype wire

// [verification/tb_calendar_clock_with_hold.sv]
// Purpose: Directed bench for the calendar clock
// Assumes: AXI4-Lite register access
// Notes: Short tick keeps the run brief
`timescale 1ns/1ns
`default_nettype none
`include "cch_params.svh"

module tb_calendar_clock_with_hold;
    localparam int unsigned TK = 50;
    logic mclk_in = 1'h0;
    logic nrst_in = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [4:0] hours_24_out, day_out;
    logic [3:0] hours_12_out, month_out;
    logic afternoon_flag_out, update_needed_out, disabled_out;
    logic [5:0] minutes_out, seconds_out;
    logic [6:0] year_out;
    cch_pkg::cch_weekday_t weekday_value_out;
    int bad_count = 0;
    int checked = 0;
    logic ce_in = 1'h1;
    logic [31:0] bad_t [9] = '{32'h00181e1e, 32'h000c3c1e, 32'h000c1e3c, 32'h000c1e1e,
        32'h000c1e1e, 32'h000c1e1e, 32'h000c1e1e, 32'h000c1e1e, 32'h000c1e1e};
    logic [31:0] bad_d [9] = '{32'h0307060f, 32'h0307060f, 32'h0307060f, 32'h03070600,
        32'h03070620, 32'h0307000f, 32'h03070d0f, 32'h0364060f, 32'h0707060f};
    logic [31:0] roll_d [5] = '{32'h0603021c, 32'h0104021c, 32'h05630c1f, 32'h0305041e,
        32'h0204021d};
    logic [18:0] roll_e [5] = '{{5'h01, 4'h3, 7'h03, 3'h0}, {5'h1d, 4'h2, 7'h04, 3'h2},
        {5'h01, 4'h1, 7'h00, 3'h6}, {5'h01, 4'h5, 7'h05, 3'h4}, {5'h01, 4'h3, 7'h04, 3'h3}};

    cch_calendar_clock #(.TICK_CYCLES(TK)) u_dut (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(1'h1),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(1'h1),
        .hours_24_out(hours_24_out),
        .hours_12_out(hours_12_out),
        .afternoon_flag_out(afternoon_flag_out),
        .minutes_out(minutes_out),
        .seconds_out(seconds_out),
        .day_out(day_out),
        .month_out(month_out),
        .year_out(year_out),
        .weekday_value_out(weekday_value_out),
        .update_needed_out(update_needed_out),
        .disabled_out(disabled_out)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        if (bad_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw;
        logic w;
        @(posedge mclk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        aw = 1'h1;
        w = 1'h1;
        while (aw || w)
        begin
            @(negedge mclk_in);
            aw = aw && (s_axi_awready !== 1'h1);
            w = w && (s_axi_wready !== 1'h1);
            @(posedge mclk_in);
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        @(negedge mclk_in);
        while (s_axi_bvalid !== 1'h1) @(negedge mclk_in);
        r = s_axi_bresp;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        @(negedge mclk_in);
        while (s_axi_arready !== 1'h1) @(negedge mclk_in);
        @(posedge mclk_in);
        s_axi_arvalid <= 1'h0;
        @(negedge mclk_in);
        while (s_axi_rvalid !== 1'h1) @(negedge mclk_in);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd

    task automatic setup(input logic [31:0] t, input logic [31:0] d);
        logic [1:0] r;
        wr(`CCH_OFS_SET_TIME, t, r);
        wr(`CCH_OFS_SET_DATE, d, r);
        wr(`CCH_OFS_CTRL, 32'h4, r);
        repeat (2) @(negedge mclk_in);
    endtask : setup

    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    initial
    begin
        forever #50 mclk_in = ~mclk_in;
    end

    initial
    begin
        #(2_000_000);
        bad_count++;
        summarize();
    end

    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [4:0] hv;
        logic [3:0] h12;
        logic [5:0] held;
        repeat (3) @(posedge mclk_in);
        nrst_in <= 1'h1;
        repeat (2) @(negedge mclk_in);
        check(32'({hours_12_out, afternoon_flag_out}), 32'({4'hc, 1'h0}));
        rd(`CCH_OFS_STATUS, d, r);
        check(d, 32'h1);
        rd(`CCH_OFS_CTRL, d, r);
        check(d, 32'h0);
        rd(12'h020, d, r);
        check(d, 32'h0);
        check(32'(r), 32'h2);
        wr(12'h020, 32'h1, r);
        check(32'(r), 32'h2);
        for (int i = 0; i < 9; i++)
        begin
            setup(bad_t[i], bad_d[i]);
            rd(`CCH_OFS_STATUS, d, r);
            check(d, 32'h5);
        end
        check(32'({hours_24_out, day_out, month_out}), 32'({5'h00, 5'h01, 4'h1}));
        for (int h = 0; h < 24; h++)
        begin
            hv = 5'(h);
            h12 = (h % 12 == 0) ? 4'hc : 4'(h % 12);
            setup({11'h000, hv, 16'h1e00}, {5'h00, 3'(h % 7), 24'h07060a});
            check(32'(hours_24_out), 32'(hv));
            check(32'({afternoon_flag_out, hours_12_out}), 32'({h >= 12, h12}));
            check(32'(weekday_value_out), 32'(h % 7));
            rd(`CCH_OFS_TIME, d, r);
            check(32'(d[25:16]), 32'({h >= 12, h12, hv}));
        end
        rd(`CCH_OFS_STATUS, d, r);
        check(d, 32'h8);
        setup(32'h00181e1e, 32'h0307060f);
        rd(`CCH_OFS_STATUS, d, r);
        check(d, 32'h4);
        check(32'(hours_24_out), 32'h17);
        for (int i = 0; i < 5; i++)
        begin
            setup(32'h00173b3b, roll_d[i]);
            while (seconds_out !== 6'h00) @(negedge mclk_in);
            check(32'({hours_24_out, minutes_out}), 32'h0);
            check(32'({day_out, month_out, year_out}), 32'(roll_e[i][18:3]));
            check(32'(weekday_value_out), 32'(roll_e[i][2:0]));
        end
        setup(32'h000a0000, 32'h0307060f);
        wr(`CCH_OFS_CTRL, 32'h1, r);
        rd(`CCH_OFS_STATUS, d, r);
        check(d, 32'ha);
        held = seconds_out;
        repeat (4 * TK) @(negedge mclk_in);
        check(32'(seconds_out), 32'(held));
        wr(`CCH_OFS_CTRL, 32'h3, r);
        rd(`CCH_OFS_STATUS, d, r);
        check(d, 32'ha);
        wr(`CCH_OFS_CTRL, 32'h2, r);
        rd(`CCH_OFS_STATUS, d, r);
        check(d, 32'h8);
        @(posedge mclk_in);
        ce_in <= 1'h0;
        repeat (2 * TK) @(negedge mclk_in);
        check(32'(6'(seconds_out - held) inside {6'h04, 6'h05}), 32'h1);
        summarize();
    end
endmodule : tb_calendar_clock_with_hold
`default_nettype wire
